// >>> core/corr_consts.vh
`ifndef CORR_CONSTS_VH
`define CORR_CONSTS_VH
// ---------------------------------------------------------------
// data widths
// ---------------------------------------------------------------
`define RAW_W 14
`define COEF_W 16
`define OUT_W 16
`define ACC_W 64
`define DIV_W 48
// ---------------------------------------------------------------
// ranges
// ---------------------------------------------------------------
`define RAW_MAX 14'h3FFF
`define RAW_HALF 64'h0000_0000_0000_2000
`define CAP_OUT_MAX 64'h0000_0000_0000_FFFF
`define TEMP_OUT_MAX 64'h0000_0000_0000_7FFF
`define TEMP_OUT_MIN 64'hFFFF_FFFF_FFFF_8000
// ---------------------------------------------------------------
// fixed point scaling (shift counts and unity denominator)
// ---------------------------------------------------------------
`define TC_SHIFT 16
`define TC_SQ_SHIFT 8
`define GAIN_SHIFT 12
`define SQ_SHIFT 20
`define CUB_PRE_SHIFT 16
`define CUB_SHIFT 20
`define T_GAIN_SHIFT 12
`define T_SQ_SHIFT 24
`define DEN_ONE 64'h0000_0000_0001_0000
// ---------------------------------------------------------------
// sequencer states
// ---------------------------------------------------------------
`define ST_IDLE 3'h0
`define ST_PREP 3'h1
`define ST_LAUNCH 3'h2
`define ST_DIV 3'h3
`define ST_REGION 3'h4
`define ST_OUT 3'h5
`endif

// >>> core/sensor_correction_math.v
// Behaviour
// - compensated raw = half + (raw - half + offset + dT*(tco+dT*sq_o)) / (1 + dT*(tcg+dT*sq_g))
// - dT is current raw temperature minus the stored reference raw temperature
// - region one takes min(comp, split); region two takes max(0, comp - split)
// - two-region output sums square*(gain*x)^2 + gain*x for each region
// - with one region and cubic mode off, region-two gain and square coefficient contribute nothing
// - cubic mode uses comp as input and region-two square slot as cubic coef
// - sensor offset coefficient acts relative to half of full-scale input
// - temperature correction applies gain, offset and second-order terms
// - raw temperature 0..16383; temperature coefs and output signed 16 bit
`timescale 1ns/1ps
`include "corr_consts.vh"
module sensor_correction_math #(
  parameter RAW_W = `RAW_W,
  parameter COEF_W = `COEF_W
) (
  input wire mclk,
  input wire rst,
  input wire start,
  input wire [RAW_W-1:0] raw_cap,
  input wire [RAW_W-1:0] raw_temp,
  input wire [RAW_W-1:0] temp_ref,
  input wire [RAW_W-1:0] split_point,
  input wire two_region_en,
  input wire cubic_mode,
  input wire signed [COEF_W-1:0] offset_coef,
  input wire signed [COEF_W-1:0] offset_drift_coef,
  input wire signed [COEF_W-1:0] offset_drift_square_coef,
  input wire signed [COEF_W-1:0] slope_drift_coef,
  input wire signed [COEF_W-1:0] slope_drift_square_coef,
  input wire signed [COEF_W-1:0] region_one_gain,
  input wire signed [COEF_W-1:0] region_one_square_coef,
  input wire signed [COEF_W-1:0] region_two_gain,
  input wire signed [COEF_W-1:0] region_two_square_coef,
  input wire signed [COEF_W-1:0] temp_gain,
  input wire signed [COEF_W-1:0] temp_offset,
  input wire signed [COEF_W-1:0] temp_square_coef,
  output wire busy,
  output reg done_q,
  output reg [`OUT_W-1:0] cap_out_q,
  output reg signed [`OUT_W-1:0] temp_out_q,
  output reg cap_sat_q,
  output reg temp_sat_q
);
  // ---------------------------------------------------------------
  // captured operands
  // ---------------------------------------------------------------
  reg [2:0] state_q;
  reg [RAW_W-1:0] rc_q, rt_q, tref_q, split_q;
  reg two_q, cub_q;
  reg signed [COEF_W-1:0] off_q, tco_q, sqo_q, tcg_q, sqg_q;
  reg signed [COEF_W-1:0] g1_q, s1_q, g2_q, s2_q, tg_q, to_q, ts_q;
  reg [`DIV_W-1:0] num_mag_q, den_mag_q;
  reg quot_neg_q, den_bad_q;
  reg signed [`ACC_W-1:0] r1_q, r2_q;
  wire [`DIV_W-1:0] quot;
  wire div_done;

  function signed [`ACC_W-1:0] sx;
    input signed [COEF_W-1:0] v;
    begin
      sx = {{(`ACC_W-COEF_W){v[COEF_W-1]}}, v};
    end
  endfunction

  function signed [`ACC_W-1:0] ux;
    input [RAW_W-1:0] v;
    begin
      ux = {{(`ACC_W-RAW_W){1'b0}}, v};
    end
  endfunction

  // ---------------------------------------------------------------
  // temperature compensation of the capacitance reading
  // ---------------------------------------------------------------
  wire signed [`ACC_W-1:0] dt = ux(rt_q) - ux(tref_q);
  wire signed [`ACC_W-1:0] inner_o = sx(tco_q) + ((dt * sx(sqo_q)) >>> `TC_SQ_SHIFT);
  wire signed [`ACC_W-1:0] inner_g = sx(tcg_q) + ((dt * sx(sqg_q)) >>> `TC_SQ_SHIFT);
  // offset coefficient acts around mid scale
  wire signed [`ACC_W-1:0] num = ux(rc_q) - $signed(`RAW_HALF) + sx(off_q)
    + ((dt * inner_o) >>> `TC_SHIFT);
  wire signed [`ACC_W-1:0] den = $signed(`DEN_ONE) + dt * inner_g;
  wire signed [`ACC_W-1:0] num_sc = num <<< `TC_SHIFT;
  wire signed [`ACC_W-1:0] num_abs = num_sc[`ACC_W-1] ? -num_sc : num_sc;

  // the quotient magnitude fits the divider for coefficients kept in bounds
  udiv_seq #(.W(`DIV_W)) u_div (
    .mclk(mclk),
    .rst(rst),
    .start(state_q == `ST_LAUNCH),
    .dividend(num_mag_q),
    .divisor(den_mag_q),
    .quotient_q(quot),
    .done_q(div_done)
  );

  wire signed [`ACC_W-1:0] q_abs = {{(`ACC_W-`DIV_W){1'b0}}, quot};
  wire signed [`ACC_W-1:0] comp_raw = (quot_neg_q ? -q_abs : q_abs) + $signed(`RAW_HALF);
  wire signed [`ACC_W-1:0] raw_max = ux(`RAW_MAX);
  wire signed [`ACC_W-1:0] comp = den_bad_q ? raw_max :
    (comp_raw < 0) ? {`ACC_W{1'b0}} : (comp_raw > raw_max) ? raw_max : comp_raw;
  wire signed [`ACC_W-1:0] split_x = ux(split_q);

  // ---------------------------------------------------------------
  // region polynomials
  // ---------------------------------------------------------------
  wire signed [`ACC_W-1:0] gx1 = (sx(g1_q) * r1_q) >>> `GAIN_SHIFT;
  wire signed [`ACC_W-1:0] gx2 = (sx(g2_q) * r2_q) >>> `GAIN_SHIFT;
  wire signed [`ACC_W-1:0] sq1 = (sx(s1_q) * gx1 * gx1) >>> `SQ_SHIFT;
  wire signed [`ACC_W-1:0] sq2 = (sx(s2_q) * gx2 * gx2) >>> `SQ_SHIFT;
  wire signed [`ACC_W-1:0] g1cub = ((gx1 * gx1) >>> `CUB_PRE_SHIFT) * gx1;
  // region-two square slot doubles as the cubic coefficient
  wire signed [`ACC_W-1:0] cub = (sx(s2_q) * g1cub) >>> `CUB_SHIFT;
  wire signed [`ACC_W-1:0] term1 = sq1 + gx1;
  wire signed [`ACC_W-1:0] term2 = (two_q && !cub_q) ? (sq2 + gx2) : {`ACC_W{1'b0}};
  wire signed [`ACC_W-1:0] cap_sum = cub_q ? (cub + term1) : (term1 + term2);

  // ---------------------------------------------------------------
  // internal temperature correction
  // ---------------------------------------------------------------
  wire signed [`ACC_W-1:0] rtx = ux(rt_q); // unsigned 0..16383
  wire signed [`ACC_W-1:0] t_sum = ((sx(tg_q) * rtx) >>> `T_GAIN_SHIFT) + sx(to_q)
    + ((sx(ts_q) * rtx * rtx) >>> `T_SQ_SHIFT);

  // ---------------------------------------------------------------
  // saturation of both results
  // ---------------------------------------------------------------
  wire cap_lo = cap_sum < 0;
  wire cap_hi = cap_sum > $signed(`CAP_OUT_MAX);
  wire t_lo = t_sum < $signed(`TEMP_OUT_MIN);
  wire t_hi = t_sum > $signed(`TEMP_OUT_MAX);
  wire [`OUT_W-1:0] cap_sat_val = cap_lo ? {`OUT_W{1'b0}} :
    cap_hi ? {`OUT_W{1'b1}} : cap_sum[`OUT_W-1:0];
  wire [`OUT_W-1:0] t_sat_val = t_lo ? {1'b1, {(`OUT_W-1){1'b0}}} :
    t_hi ? {1'b0, {(`OUT_W-1){1'b1}}} : t_sum[`OUT_W-1:0];

  assign busy = state_q != `ST_IDLE;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= `ST_IDLE;
      rc_q <= {RAW_W{1'b0}};
      rt_q <= {RAW_W{1'b0}};
      tref_q <= {RAW_W{1'b0}};
      split_q <= {RAW_W{1'b0}};
      two_q <= 1'b0;
      cub_q <= 1'b0;
      off_q <= {COEF_W{1'b0}};
      tco_q <= {COEF_W{1'b0}};
      sqo_q <= {COEF_W{1'b0}};
      tcg_q <= {COEF_W{1'b0}};
      sqg_q <= {COEF_W{1'b0}};
      g1_q <= {COEF_W{1'b0}};
      s1_q <= {COEF_W{1'b0}};
      g2_q <= {COEF_W{1'b0}};
      s2_q <= {COEF_W{1'b0}};
      tg_q <= {COEF_W{1'b0}};
      to_q <= {COEF_W{1'b0}};
      ts_q <= {COEF_W{1'b0}};
      num_mag_q <= {`DIV_W{1'b0}};
      den_mag_q <= {`DIV_W{1'b0}};
      quot_neg_q <= 1'b0;
      den_bad_q <= 1'b0;
      r1_q <= {`ACC_W{1'b0}};
      r2_q <= {`ACC_W{1'b0}};
      done_q <= 1'b0;
      cap_out_q <= {`OUT_W{1'b0}};
      temp_out_q <= {`OUT_W{1'b0}};
      cap_sat_q <= 1'b0;
      temp_sat_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        `ST_IDLE:
        begin
          if (start)
          begin
            rc_q <= raw_cap;
            rt_q <= raw_temp;
            tref_q <= temp_ref;
            split_q <= split_point;
            two_q <= two_region_en;
            cub_q <= cubic_mode;
            off_q <= offset_coef;
            tco_q <= offset_drift_coef;
            sqo_q <= offset_drift_square_coef;
            tcg_q <= slope_drift_coef;
            sqg_q <= slope_drift_square_coef;
            g1_q <= region_one_gain;
            s1_q <= region_one_square_coef;
            g2_q <= region_two_gain;
            s2_q <= region_two_square_coef;
            tg_q <= temp_gain;
            to_q <= temp_offset;
            ts_q <= temp_square_coef;
            state_q <= `ST_PREP;
          end
        end
        `ST_PREP:
        begin
          num_mag_q <= num_abs[`DIV_W-1:0];
          den_mag_q <= den[`DIV_W-1:0];
          quot_neg_q <= num_sc[`ACC_W-1];
          // a non-positive denominator drives the result to full scale
          den_bad_q <= den <= 0;
          state_q <= `ST_LAUNCH;
        end
        `ST_LAUNCH:
          state_q <= `ST_DIV;
        `ST_DIV:
        begin
          if (div_done)
            state_q <= `ST_REGION;
        end
        `ST_REGION:
        begin
          if (cub_q)
          begin
            r1_q <= comp;
            r2_q <= {`ACC_W{1'b0}};
          end
          else
          begin
            r1_q <= (comp < split_x) ? comp : split_x;
            r2_q <= (comp > split_x) ? (comp - split_x) : {`ACC_W{1'b0}};
          end
          state_q <= `ST_OUT;
        end
        `ST_OUT:
        begin
          cap_out_q <= cap_sat_val;
          temp_out_q <= t_sat_val;
          cap_sat_q <= cap_lo | cap_hi;
          temp_sat_q <= t_lo | t_hi;
          done_q <= 1'b1;
          state_q <= `ST_IDLE;
        end
        default:
          state_q <= `ST_IDLE;
      endcase
    end
  end
endmodule // sensor_correction_math

// >>> core/udiv_seq.v
`timescale 1ns/1ps
`include "corr_consts.vh"
// restoring unsigned divider, one quotient bit per cycle
module udiv_seq #(
  parameter W = 48
) (
  input wire mclk,
  input wire rst,
  input wire start,
  input wire [W-1:0] dividend,
  input wire [W-1:0] divisor,
  output reg [W-1:0] quotient_q,
  output reg done_q
);
  reg [W-1:0] rem_q;
  reg [W-1:0] dvd_q;
  reg [W-1:0] dvs_q;
  reg [6:0] cnt_q;
  reg run_q;
  wire [W:0] trial = {rem_q, dvd_q[W-1]} - {1'b0, dvs_q};

  always @(posedge mclk)
  begin
    if (rst)
    begin
      rem_q <= {W{1'b0}};
      dvd_q <= {W{1'b0}};
      dvs_q <= {W{1'b0}};
      quotient_q <= {W{1'b0}};
      cnt_q <= 7'h00;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
      begin
        rem_q <= {W{1'b0}};
        dvd_q <= dividend;
        dvs_q <= divisor;
        cnt_q <= W[6:0];
        run_q <= 1'b1;
      end
      else if (run_q)
      begin
        dvd_q <= {dvd_q[W-2:0], ~trial[W]};
        if (!trial[W])
          rem_q <= trial[W-1:0];
        else
          rem_q <= {rem_q[W-2:0], dvd_q[W-1]};
        cnt_q <= cnt_q - 7'h01;
        if (cnt_q == 7'h01)
        begin
          run_q <= 1'b0;
          done_q <= 1'b1;
          // a zero divisor naturally yields all ones
          quotient_q <= {dvd_q[W-2:0], ~trial[W]};
        end
      end
    end
  end
endmodule // udiv_seq

// >>> tb/conv_frontend.sv
`timescale 1ns/1ps
module conv_frontend (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req,
  input wire logic [13:0] cap_in,
  input wire logic [13:0] temp_in,
  output logic [13:0] raw_cap = 14'h0000,
  output logic [13:0] raw_temp = 14'h0000,
  output logic start = 1'b0
);
  // readings are valid only in the start cycle, scrambled afterwards
  always @(posedge mclk)
  begin
    start <= req & ~rst;
    if (req)
    begin
      raw_cap <= cap_in;
      raw_temp <= temp_in;
    end
    else if (start)
    begin
      raw_cap <= ~raw_cap;
      raw_temp <= ~raw_temp;
    end
  end
endmodule // conv_frontend

// >>> tb/corr_properties.sv
`timescale 1ns/1ps
module corr_properties (
  input wire mclk,
  input wire rst,
  input wire start,
  input wire busy,
  input wire done_q,
  input wire [15:0] cap_out_q,
  input wire signed [15:0] temp_out_q,
  input wire cap_sat_q,
  input wire temp_sat_q
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_take;
    start && !busy;
  endsequence
  sequence s_run;
    busy [*8];
  endsequence
  a_take_busy: assert property (s_take |=> s_run)
    else $error("busy not held after start");
  a_done_latency: assert property (s_take |-> ##54 done_q)
    else $error("result not ready 54 cycles after start");
  a_no_early: assert property (s_take |=> (!done_q) [*8])
    else $error("result ready too early");
  a_done_pulse: assert property (done_q |=> !done_q && !busy)
    else $error("done not a single cycle ending busy");
  a_done_busy: assert property (done_q |-> !busy)
    else $error("done while still busy");
  a_out_hold: assert property (!done_q |-> $stable(cap_out_q) && $stable(temp_out_q))
    else $error("result changed without done");
  a_flag_hold: assert property (!done_q |-> $stable({cap_sat_q, temp_sat_q}))
    else $error("clip flags changed without done");
  a_cap_clip: assert property (cap_sat_q |-> cap_out_q == 16'hFFFF || cap_out_q == 16'h0000)
    else $error("clipped capacitance not at a limit");
  a_temp_clip: assert property (temp_sat_q |-> temp_out_q == 16'h7FFF || temp_out_q == 16'h8000)
    else $error("clipped temperature not at a limit");
endmodule // corr_properties

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic two_r = 1'b0;
  logic cub = 1'b0;
  longint cap_in = 0;
  longint t_in = 0;
  longint tref = 0;
  longint split = 16383;
  longint c [12] = '{default: 0};
  logic [13:0] raw_cap;
  logic [13:0] raw_temp;
  logic start;
  logic busy;
  logic done_q;
  logic [15:0] cap_out_q;
  logic signed [15:0] temp_out_q;
  logic cap_sat_q;
  logic temp_sat_q;
  int n_errors = 0;
  int num_checks = 0;
  always #5 mclk = ~mclk;
  conv_frontend i_conv_frontend (.mclk(mclk), .rst(rst), .req(req), .cap_in(cap_in[13:0]),
    .temp_in(t_in[13:0]), .raw_cap(raw_cap), .raw_temp(raw_temp), .start(start));
  sensor_correction_math i_sensor_correction_math (.mclk(mclk), .rst(rst), .start(start),
    .raw_cap(raw_cap), .raw_temp(raw_temp), .temp_ref(tref[13:0]),
    .split_point(split[13:0]), .two_region_en(two_r), .cubic_mode(cub),
    .offset_coef(c[0][15:0]), .offset_drift_coef(c[1][15:0]),
    .offset_drift_square_coef(c[2][15:0]), .slope_drift_coef(c[3][15:0]),
    .slope_drift_square_coef(c[4][15:0]), .region_one_gain(c[5][15:0]),
    .region_one_square_coef(c[6][15:0]), .region_two_gain(c[7][15:0]),
    .region_two_square_coef(c[8][15:0]), .temp_gain(c[9][15:0]),
    .temp_offset(c[10][15:0]), .temp_square_coef(c[11][15:0]), .busy(busy),
    .done_q(done_q), .cap_out_q(cap_out_q), .temp_out_q(temp_out_q),
    .cap_sat_q(cap_sat_q), .temp_sat_q(temp_sat_q));
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  function automatic longint term(longint k, longint sq, longint cb, longint x);
    longint g;
    g = (k * x) >>> 12;
    return ((sq * g * g) >>> 20) + ((cb * (((g * g) >>> 16) * g)) >>> 20) + g;
  endfunction
  task automatic model(output longint ec, output longint et);
    longint dt;
    longint num;
    longint den;
    longint cp;
    dt = t_in - tref;
    num = cap_in - 8192 + c[0] + ((dt * (c[1] + ((dt * c[2]) >>> 8))) >>> 16);
    den = 65536 + dt * (c[3] + ((dt * c[4]) >>> 8));
    cp = (den <= 0) ? 16383 : num * 65536 / den + 8192;
    cp = cp < 0 ? 0 : (cp > 16383 ? 16383 : cp);
    if (cub)
      ec = term(c[5], c[6], c[8], cp);
    else
      ec = term(c[5], c[6], 0, cp < split ? cp : split);
    if (two_r && !cub)
      ec += term(c[7], c[8], 0, cp > split ? cp - split : 0);
    et = ((c[9] * t_in) >>> 12) + c[10] + ((c[11] * t_in * t_in) >>> 24);
  endtask
  task automatic run(input bit poke);
    longint ec;
    longint et;
    int n;
    @(posedge mclk);
    req <= 1'b1;
    @(posedge mclk);
    req <= 1'b0;
    model(ec, et);
    if (poke)
    begin
      repeat (10) @(posedge mclk);
      cap_in <= cap_in ^ 1234;
      req <= 1'b1;
      @(posedge mclk);
      req <= 1'b0;
    end
    n = 0;
    while (done_q !== 1'b1 && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    chk("done_q", 1'b1, done_q);
    chk("cap_out_q", ec < 0 ? 0 : (ec > 65535 ? 65535 : ec), cap_out_q);
    chk("temp_out_q", et < -32768 ? -32768 : (et > 32767 ? 32767 : et), temp_out_q);
    chk("cap_sat_q", ec < 0 || ec > 65535, cap_sat_q);
    chk("temp_sat_q", et < -32768 || et > 32767, temp_sat_q);
    // hand back on a rising edge so the next stimulus lands there
    @(posedge mclk);
  endtask
  task automatic clear;
    @(posedge mclk);
    foreach (c[i]) c[i] <= (i == 5) ? 4096 : 0;
    two_r <= 1'b0;
    cub <= 1'b0;
    split <= 16383;
    t_in <= 8000;
    tref <= 8000;
    @(posedge mclk);
  endtask
  task automatic s_region;
    longint cv [2] = '{9000, 12000};
    clear();
    two_r <= 1'b1;
    split <= 10000;
    c[6] <= 200;
    c[7] <= 6000;
    c[8] <= -300;
    foreach (cv[i])
    begin
      cap_in <= cv[i];
      run(1'b0);
    end
  endtask
  task automatic s_drift;
    longint tv [2] = '{9000, 7000};
    clear();
    cap_in <= 10000;
    c[0] <= 50;
    c[1] <= 500; // drift kept within calibrated bounds
    c[2] <= 40;
    c[3] <= 30;
    c[4] <= 2;
    foreach (tv[i])
    begin
      t_in <= tv[i];
      run(1'b0);
    end
  endtask
  task automatic s_modes;
    clear();
    cap_in <= 12000;
    c[7] <= 20000;
    c[8] <= 5000;
    run(1'b0);
    two_r <= 1'b1;
    cub <= 1'b1;
    split <= 5000;
    cap_in <= 9000;
    c[6] <= 100;
    c[8] <= 3000;
    run(1'b0);
    cub <= 1'b0;
    two_r <= 1'b0;
    split <= 16383;
    cap_in <= 8192;
    c[0] <= 100;
    // gain drift makes the mid-scale centring visible in the result
    t_in <= 9000;
    c[3] <= 20;
    run(1'b1);
  endtask
  task automatic s_temp;
    longint tv [3] = '{0, 5000, 16383};
    clear();
    cap_in <= 8192;
    c[9] <= 3000;
    c[10] <= -200;
    c[11] <= 500;
    foreach (tv[i])
    begin
      t_in <= tv[i];
      run(1'b0);
    end
    c[9] <= 32767;
    c[10] <= 32767;
    c[5] <= 32767;
    cap_in <= 16383;
    run(1'b0);
    c[9] <= -32768;
    c[10] <= -32768;
    c[5] <= -32768;
    run(1'b0);
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    s_region();
    s_drift();
    s_modes();
    s_temp();
    print_verdict();
  end
  initial
  begin
    #50000;
    n_errors++;
    print_verdict();
  end
endmodule // tb
bind sensor_correction_math corr_properties i_corr_properties (.mclk, .rst, .start, .busy,
  .done_q, .cap_out_q, .temp_out_q, .cap_sat_q, .temp_sat_q);
